//--- verilog/pca_module.sv
`timescale 1ns/100ps
`default_nettype none
module pca_module
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic is_wdog,
    input wire logic [15:0] count,
    input wire logic low_wrap,
    input wire logic mode_we,
    input wire logic [6:0] mode_wdata,
    input wire logic cmp_low_we,
    input wire logic cmp_high_we,
    input wire logic [7:0] wdata,
    input wire logic flag_clear,
    input wire logic wdog_enable,
    input wire logic pin_in,
    output logic [6:0] mode,
    output logic [7:0] cmp_low,
    output logic [7:0] cmp_high,
    output logic [7:0] duty_active,
    output logic event_flag,
    output logic irq,
    output logic pin_out,
    output logic pin_oe,
    output logic wdog_reset
);
    import pca_pkg::*;
    typedef struct packed
    {
        logic [6:0] mode;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] duty;
        logic flag;
        logic tog_out;
        logic wdog;
    } pca_mod_t;
    pca_mod_t s_reg;
    pca_mod_t s_next;
    logic rise;
    logic fall;
    logic match;
    logic cap;
    pca_pin_sync u_sync
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_in(pin_in),
        .rise(rise),
        .fall(fall)
    );
    // ****************************************
    // event logic
    // ****************************************
    // [R17]
    assign match = s_reg.mode[BIT_COMP_EN] && (count == {s_reg.hi, s_reg.lo});
    assign cap = (rise && s_reg.mode[BIT_CAP_POS]) || (fall && s_reg.mode[BIT_CAP_NEG]); // [R1]
    always_comb
    begin
        s_next = s_reg;
        s_next.wdog = 1'b0;
        if (mode_we)
        begin
            s_next.mode = mode_wdata;
        end
        if (cmp_low_we)
        begin
            s_next.lo = wdata;
            s_next.mode[BIT_COMP_EN] = 1'b0; // [R6]
        end
        if (cmp_high_we)
        begin
            s_next.hi = wdata;
            s_next.mode[BIT_COMP_EN] = 1'b1; // [R5]
        end
        if (cap)
        begin
            s_next.hi = count[15:8]; // [R2]
            s_next.lo = count[7:0]; // [R2]
        end
        if (flag_clear)
        begin
            s_next.flag = 1'b0;
        end
        // set beats clear; flag stays until software clears it
        if (cap || (match && s_reg.mode[BIT_MATCH])) // [R4] [R21]
        begin
            s_next.flag = 1'b1;
        end
        if (match && s_reg.mode[BIT_MATCH] && s_reg.mode[BIT_TOGGLE])
        begin
            s_next.tog_out = ~s_reg.tog_out; // [R9]
        end
        if (low_wrap)
        begin
            s_next.duty = s_reg.hi; // [R11]
        end
        // watchdog only on module 4, gated by enable at match time
        if (is_wdog && wdog_enable && match && s_reg.mode[BIT_MATCH]) // [R13] [R14] [R15]
        begin
            s_next.wdog = 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
    // ****************************************
    // outputs
    // ****************************************
    assign mode = s_reg.mode;
    assign cmp_low = s_reg.lo;
    assign cmp_high = s_reg.hi;
    assign duty_active = s_reg.duty;
    assign event_flag = s_reg.flag;
    assign irq = s_reg.flag && s_reg.mode[BIT_IRQ_EN]; // [R3] [R19]
    assign wdog_reset = s_reg.wdog;
    always_comb
    begin
        pin_oe = 1'b0;
        pin_out = 1'b1;
        if (s_reg.mode[BIT_PWM] && s_reg.mode[BIT_COMP_EN]) // [R12]
        begin
            pin_oe = 1'b1;
            pin_out = (count[7:0] >= s_reg.duty); // [R10]
        end
        else if (s_reg.mode[BIT_TOGGLE])
        begin
            pin_oe = 1'b1;
            pin_out = s_reg.tog_out;
        end
    end
endmodule // pca_module
`default_nettype wire

//--- verilog/pca_pkg.sv
// Summary of operation
// [R1] capture runs when negative or positive edge enable set; both edges if both set
// [R2] valid selected pin edge copies counter high and low bytes into compare bytes
// [R3] interrupt request needs both event flag and flag interrupt enable set
// [R4] comparator and match enables set: counter equal compare sets event flag
// [R5] writing high compare byte also sets comparator enable
// [R6] writing low compare byte also clears comparator enable
// [R7] software writes low compare byte first, then high byte
// [R8] software loads nonzero compare value before enabling comparator
// [R9] toggle, match and comparator enables set: output inverts on every match
// [R10] pwm output low while counter low byte below duty, else high
// [R11] counter low byte wrap FF to 00 reloads duty byte from high compare byte
// [R12] pwm output only with pwm and comparator enables; shared counter, shared frequency
// [R13] only module 4 has watchdog; otherwise usable in any mode
// [R14] watchdog match with module 4 compare value gives internal reset, not pin
// [R15] clearing watchdog enable before match suppresses reset; setting it re-arms
// [R16] software moves compare value ahead rather than disabling watchdog
// [R17] one shared counter times all modules; counter writes affect all
// [R18] mode bits: irq 0, pwm 1, toggle 2, match 3, neg 4, pos 5, comparator 6
// [R19] flag interrupt enable lets event flag request interrupt on match or capture
// [R20] pin synchronised, edges found from successive synchronised samples
// [R21] event flag stays set until software clears it
package pca_pkg;
    localparam int NUM_MODULES = 5;
    localparam int WDOG_MODULE = 4;
    localparam int MODE_W = 7;
    // ****************************************
    // mode register fields
    // ****************************************
    localparam int BIT_IRQ_EN = 0; // [R18]
    localparam int BIT_PWM = 1; // [R18]
    localparam int BIT_TOGGLE = 2; // [R18]
    localparam int BIT_MATCH = 3; // [R18]
    localparam int BIT_CAP_NEG = 4; // [R18]
    localparam int BIT_CAP_POS = 5; // [R18]
    localparam int BIT_COMP_EN = 6; // [R18]
    // ****************************************
    // reset values and low byte wrap point
    // ****************************************
    localparam logic [6:0] MODE_RESET = 7'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] LOW_WRAP = 8'hFF;
endpackage : pca_pkg

//--- verilog/pca_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pca_pin_sync
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic rise,
    output logic fall
);
    typedef struct packed
    {
        logic [2:0] sh;
        logic level;
    } pca_sync_t;
    pca_sync_t state_reg;
    pca_sync_t state_next;
    // ****************************************
    // three stages; second and third must agree
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.sh = {state_reg.sh[1:0], pin_in};
        if (state_reg.sh[2] == state_reg.sh[1])
        begin
            state_next.level = state_reg.sh[2]; // [R20]
        end
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    // edge from successive filtered samples
    assign rise = state_next.level & ~state_reg.level; // [R20]
    assign fall = ~state_next.level & state_reg.level; // [R20]
endmodule // pca_pin_sync
`default_nettype wire

//--- verilog/pca_top.sv
`timescale 1ns/100ps
`default_nettype none
module pca_top
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic count_run,
    input wire logic count_we,
    input wire logic [15:0] count_wdata,
    input wire logic [pca_pkg::NUM_MODULES-1:0] mode_we,
    input wire logic [6:0] mode_wdata,
    input wire logic [pca_pkg::NUM_MODULES-1:0] cmp_low_we,
    input wire logic [pca_pkg::NUM_MODULES-1:0] cmp_high_we,
    input wire logic [7:0] cmp_wdata,
    input wire logic [pca_pkg::NUM_MODULES-1:0] flag_clear,
    input wire logic watchdog_enable_bit,
    input wire logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_in,
    output logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_out,
    output logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_oe,
    output logic [15:0] counter_value,
    output logic [pca_pkg::NUM_MODULES*7-1:0] module_mode_reg,
    output logic [pca_pkg::NUM_MODULES*8-1:0] compare_low_byte,
    output logic [pca_pkg::NUM_MODULES*8-1:0] compare_high_byte,
    output logic [pca_pkg::NUM_MODULES*8-1:0] pwm_duty_active,
    output logic [pca_pkg::NUM_MODULES-1:0] module_event_flag,
    output logic irq_request,
    output logic internal_reset
);
    import pca_pkg::*;
    typedef struct packed
    {
        logic [15:0] count;
        logic wrap;
    } pca_top_t;
    pca_top_t s_reg;
    pca_top_t s_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [NUM_MODULES-1:0] irq_vec;
    logic [NUM_MODULES-1:0] wdog_vec;
    // ****************************************
    // reset release
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];
    // ****************************************
    // shared counter
    // ****************************************
    always_comb
    begin
        s_next = s_reg;
        s_next.wrap = 1'b0;
        if (count_we)
        begin
            s_next.count = count_wdata; // [R17]
        end
        else if (count_run)
        begin
            s_next.count = s_reg.count + 16'h0001;
            s_next.wrap = (s_reg.count[7:0] == LOW_WRAP); // [R11]
        end
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
    // ****************************************
    // modules
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < NUM_MODULES; i++)
        begin : g_mod
            pca_module u_mod
            (
                .mclk(mclk),
                .rst_n(rst_n),
                .is_wdog(i == WDOG_MODULE),
                .count(s_reg.count),
                .low_wrap(s_reg.wrap),
                .mode_we(mode_we[i]),
                .mode_wdata(mode_wdata),
                .cmp_low_we(cmp_low_we[i]),
                .cmp_high_we(cmp_high_we[i]),
                .wdata(cmp_wdata),
                .flag_clear(flag_clear[i]),
                .wdog_enable(watchdog_enable_bit),
                .pin_in(module_io_pin_in[i]),
                .mode(module_mode_reg[i*7 +: 7]),
                .cmp_low(compare_low_byte[i*8 +: 8]),
                .cmp_high(compare_high_byte[i*8 +: 8]),
                .duty_active(pwm_duty_active[i*8 +: 8]),
                .event_flag(module_event_flag[i]),
                .irq(irq_vec[i]),
                .pin_out(module_io_pin_out[i]),
                .pin_oe(module_io_pin_oe[i]),
                .wdog_reset(wdog_vec[i])
            );
        end
    endgenerate
    assign counter_value = s_reg.count;
    assign irq_request = |irq_vec; // [R3]
    // internal only; the reset pin is never driven
    assign internal_reset = |wdog_vec; // [R14]
endmodule // pca_top
`default_nettype wire

//--- verification/pca_props.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// checker
// ****
module pca_props
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic count_run,
    input wire logic count_we,
    input wire logic [4:0] cmp_low_we,
    input wire logic [4:0] cmp_high_we,
    input wire logic [4:0] flag_clear,
    input wire logic watchdog_enable_bit,
    input wire logic [4:0] module_io_pin_out,
    input wire logic [15:0] counter_value,
    input wire logic [34:0] module_mode_reg,
    input wire logic [39:0] compare_low_byte,
    input wire logic [39:0] compare_high_byte,
    input wire logic [39:0] pwm_duty_active,
    input wire logic [4:0] module_event_flag,
    input wire logic irq_request,
    input wire logic internal_reset
);
    logic [6:0] m0, m1, m2, m4;
    logic [15:0] c0, c1, c4;
    assign m0 = module_mode_reg[6:0];
    assign m1 = module_mode_reg[13:7];
    assign m2 = module_mode_reg[20:14];
    assign m4 = module_mode_reg[34:28];
    assign c0 = {compare_high_byte[7:0], compare_low_byte[7:0]};
    assign c1 = {compare_high_byte[15:8], compare_low_byte[15:8]};
    assign c4 = {compare_high_byte[39:32], compare_low_byte[39:32]};
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // reload may land on the wrap edge or one later
    sequence s_wrap;
        m2[1] && m2[6] && count_run && !count_we && counter_value[7:0] == 8'hFF
            ##1 $stable(compare_high_byte[23:16]);
    endsequence
    sequence s_wd_hit;
        watchdog_enable_bit && m4[6] && m4[3] && counter_value == c4;
    endsequence
    AST_HI_SETS_EN: assert property (cmp_high_we[0] |=> m0[6])
        else $error("enable not set");
    AST_LO_CLR_EN: assert property (cmp_low_we[0] && !cmp_high_we[0] |=> !m0[6])
        else $error("enable not cleared");
    AST_MATCH: assert property (m0[6] && m0[3] && counter_value == c0
        |=> module_event_flag[0])
        else $error("match flag missing");
    AST_FLAG_HOLD: assert property (module_event_flag[0] && !flag_clear[0]
        |=> module_event_flag[0])
        else $error("flag lost");
    AST_IRQ: assert property (irq_request == |(module_event_flag &
        {module_mode_reg[28], module_mode_reg[21], module_mode_reg[14],
        module_mode_reg[7], module_mode_reg[0]}))
        else $error("irq wrong");
    AST_TOGGLE: assert property (m1[6] && m1[3] && m1[2] && !m1[1]
        && counter_value == c1
        |=> module_io_pin_out[1] != $past(module_io_pin_out[1]))
        else $error("no toggle");
    AST_PWM: assert property (m2[1] && m2[6]
        |-> module_io_pin_out[2] == (counter_value[7:0] >= pwm_duty_active[23:16]))
        else $error("pwm level");
    AST_RELOAD: assert property (s_wrap
        |-> ##[0:1] pwm_duty_active[23:16] == compare_high_byte[23:16])
        else $error("no reload");
    AST_WD_FIRE: assert property (s_wd_hit |=> internal_reset)
        else $error("no watchdog reset");
    AST_WD_OFF: assert property (!watchdog_enable_bit |=> !internal_reset)
        else $error("reset while off");
    // any other module matching must never reach the internal reset
    AST_WD_CAUSE: assert property (internal_reset
        |-> $past(watchdog_enable_bit && m4[6] && m4[3] && counter_value == c4))
        else $error("reset without module 4 match");
endmodule // pca_props
bind pca_top pca_props u_props (.mclk(mclk), .reset_n(reset_n), .count_run(count_run),
    .count_we(count_we), .cmp_low_we(cmp_low_we), .cmp_high_we(cmp_high_we),
    .flag_clear(flag_clear), .watchdog_enable_bit(watchdog_enable_bit),
    .module_io_pin_out(module_io_pin_out), .counter_value(counter_value),
    .module_mode_reg(module_mode_reg), .compare_low_byte(compare_low_byte),
    .compare_high_byte(compare_high_byte), .pwm_duty_active(pwm_duty_active),
    .module_event_flag(module_event_flag), .irq_request(irq_request),
    .internal_reset(internal_reset));
`default_nettype wire

//--- verification/pca_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// pin driver
// ****
module pca_pin_model
(
    input wire logic [4:0] level,
    output logic [4:0] pins
);
    // edges land off the clock, like a real async source
    assign #1 pins = level;
endmodule // pca_pin_model
`default_nettype wire

//--- verification/pca_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pca_top_tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic run = 1'b0;
    logic cwe = 1'b0;
    logic wd_en = 1'b0;
    logic [15:0] wdat = 16'h0000;
    logic [4:0] mwe = 5'h00, lwe = 5'h00, hwe = 5'h00, fclr = 5'h00, lvl = 5'h00;
    logic [4:0] pins, pout, oe, flags;
    logic [15:0] cnt;
    logic [34:0] modes;
    logic [39:0] lo, hi, duty;
    logic irq, rst;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    pca_pin_model u_pins (.level(lvl), .pins(pins));
    pca_top dut (.mclk(mclk), .reset_n(reset_n), .count_run(run), .count_we(cwe),
        .count_wdata(wdat), .mode_we(mwe), .mode_wdata(wdat[6:0]), .cmp_low_we(lwe),
        .cmp_high_we(hwe), .cmp_wdata(wdat[7:0]), .flag_clear(fclr),
        .watchdog_enable_bit(wd_en), .module_io_pin_in(pins), .module_io_pin_out(pout),
        .module_io_pin_oe(oe), .counter_value(cnt), .module_mode_reg(modes),
        .compare_low_byte(lo), .compare_high_byte(hi), .pwm_duty_active(duty),
        .module_event_flag(flags), .irq_request(irq), .internal_reset(rst));
    always #2 mclk = ~mclk;
    // whole run needs well under 400 cycles
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            num_errors++;
            end_sim();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (e !== g)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // k: 0 mode, 1 low byte, 2 high byte, 3 flag clear, 4 counter
    task automatic wr(input int k, input int i, input logic [15:0] v);
        wdat = v;
        mwe[i] = (k == 0);
        lwe[i] = (k == 1);
        hwe[i] = (k == 2);
        fclr[i] = (k == 3);
        cwe = (k == 4);
        tick(1);
        {mwe, lwe, hwe, fclr, cwe} = 21'h00000;
        // idle cycle so a strobe is never driven twice in one step
        tick(1);
    endtask
    task automatic t_compare();
        wr(1, 0, 16'h0034);
        chk("comp_en", 16'h0000, {15'h0000, modes[6]});
        wr(2, 0, 16'h0012);
        chk("comp_en", 16'h0001, {15'h0000, modes[6]});
        wr(0, 0, 16'h0049);
        wr(4, 0, 16'h1234);
        tick(1);
        chk("flag_irq", 16'h0003, {14'h0000, flags[0], irq});
        wr(0, 0, 16'h0048);
        wr(4, 0, 16'h0000);
        chk("flag_irq", 16'h0002, {14'h0000, flags[0], irq});
        wr(3, 0, 16'h0000);
        chk("flag", 16'h0000, {15'h0000, flags[0]});
    endtask
    task automatic t_toggle();
        logic p;
        wr(1, 1, 16'h0000);
        wr(2, 1, 16'h0011);
        wr(0, 1, 16'h004C);
        wr(4, 0, 16'h10FC);
        p = pout[1];
        run = 1'b1;
        tick(10);
        run = 1'b0;
        chk("toggle", {14'h0000, 1'b1, ~p}, {14'h0000, oe[1], pout[1]});
    endtask
    task automatic t_pwm();
        wr(2, 2, 16'h0040);
        wr(0, 2, 16'h0042);
        wr(4, 0, 16'h00F0);
        run = 1'b1;
        tick(20);
        run = 1'b0;
        chk("duty", 16'h0040, {8'h00, duty[23:16]});
        chk("count", 16'h0104, cnt);
        wr(4, 0, 16'h003F);
        chk("pwm", 16'h0002, {14'h0000, oe[2], pout[2]});
        wr(4, 0, 16'h0040);
        chk("pwm", 16'h0003, {14'h0000, oe[2], pout[2]});
        wr(1, 2, 16'h0080);
        chk("pwm_off", 16'h0001, {14'h0000, oe[2], pout[2]});
    endtask
    task automatic t_capture();
        logic [15:0] v;
        for (int k = 0; k < 3; k++)
        begin
            v = 16'hABCD + 16'(k) * 16'h1111;
            wr(0, 3, (k == 0) ? 16'h0021 : (k == 1) ? 16'h0011 : 16'h0031);
            wr(4, 0, v);
            lvl[3] = ~lvl[3];
            tick(8);
            chk("capture", v, {hi[31:24], lo[31:24]});
            chk("cap_irq", 16'h0003, {14'h0000, flags[3], irq});
            wr(3, 3, 16'h0000);
        end
    endtask
    task automatic t_wdog();
        int n;
        wr(1, 4, 16'h0000);
        wr(2, 4, 16'h0001);
        wr(0, 4, 16'h0048);
        for (int k = 0; k < 4; k++)
        begin
            wd_en = (k != 1);
            n = 0;
            // last pass keeps the watchdog armed but moves the compare value ahead
            if (k == 3)
            begin
                wr(1, 4, 16'h0000);
                wr(2, 4, 16'h0002);
            end
            wr(4, 0, 16'h00FC);
            run = 1'b1;
            repeat (10)
            begin
                tick(1);
                n = n + int'(rst);
            end
            run = 1'b0;
            chk("wdog", 16'((k % 2) == 0), 16'(n));
        end
    endtask
    task automatic end_sim();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        tick(20);
        reset_n = 1'b1;
        tick(3);
        chk("reset", 16'h001F, {|{cnt, modes, lo, hi, duty, flags, irq, rst}, 5'h00, oe, pout});
        t_compare();
        t_toggle();
        t_pwm();
        t_capture();
        t_wdog();
        end_sim();
    end
endmodule // pca_top_tb
`default_nettype wire
